// ==== common/rps_pkg.sv ====
// Constants, types and register map of the power and start-up sequencer
package rps_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int CFG_W  = 5;

	// Register offsets
	localparam logic [5:0] A_PAGE   = 6'h00;
	localparam logic [5:0] A_CMD    = 6'h01;
	localparam logic [5:0] A_STATUS = 6'h05;
	localparam logic [5:0] A_CTRL   = 6'h09;
	localparam logic [5:0] A_TXCTL  = 6'h0A;
	localparam logic [5:0] CFG_LO   = 6'h10;
	localparam logic [5:0] CFG_HI   = 6'h2F;

	// Field positions
	localparam int CTRL_SLEEP = 4;
	localparam int CTRL_STBY  = 5;
	localparam int TX1_EN     = 0;
	localparam int TX2_EN     = 1;
	localparam int TX2_INV    = 3;
	localparam int RX_AUTO    = 4;
	localparam int ST_SLEEP   = 0;
	localparam int ST_STBY    = 1;
	localparam int ST_IFACE   = 2;
	localparam int ST_LINEAR  = 3;
	localparam int ST_RUN     = 4;

	// Reset values and codes
	localparam logic [7:0] TXCTL_RST   = 8'h00;
	localparam logic [7:0] PAGE_RST    = 8'h00;
	localparam logic [5:0] CMD_STARTUP = 6'h3F;
	localparam logic [5:0] CMD_IDLE    = 6'h00;
	localparam logic [7:0] PAGE_IFACE  = 8'h80;
	localparam logic [7:0] PAGE_LINEAR = 8'h00;

	// Counts in oscillator edges and number of configuration words
	localparam int RESET_CYC      = 512;
	localparam int INIT_CYC       = 128;
	localparam int SLEEP_EXIT_CYC = 512;
	localparam int STBY_EXIT_CYC  = 4;
	localparam int CFG_WORDS      = 32;

	// Least hold time of the power-down pin, kept by the far side
	localparam int CLK_NS      = 20;
	localparam int T_PD_MIN_NS = 100000;
	localparam int PD_MIN_CYC  = (T_PD_MIN_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [4:0] {
		S_PD   = 5'b00001,
		S_OSC  = 5'b00010,
		S_RST  = 5'b00100,
		S_INIT = 5'b01000,
		S_RUN  = 5'b10000
	} rps_seq_e;

	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rps_bus_s;

	typedef struct packed {
		logic irq;
		logic irq_oe;
		logic aux;
		logic aux_oe;
		logic aux_serial;
		logic tx1;
		logic tx2;
	} rps_pins_s;
endpackage

// ==== logic/rps_osc_cnt.sv ====
// Counter of qualified oscillator edges with a done flag
`timescale 1ns/1ps
module rps_osc_cnt #(
	parameter int LIMIT = 512,
	parameter int W     = $clog2(LIMIT + 1)
) (
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	input  wire logic         clear,
	input  wire logic         tick,
	output logic [W-1:0]      cnt_q,
	output logic              done_q
);
	if (LIMIT < 1 || W < $clog2(LIMIT + 1)) begin : g_bad
		$error("rps_osc_cnt: LIMIT or W out of range");
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst || clear) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else if (tick && !done_q) begin
			cnt_q  <= cnt_q + W'(1);
			done_q <= (cnt_q == W'(LIMIT - 1));
		end
	end
endmodule // rps_osc_cnt

// ==== logic/rps_cfg_mem.sv ====
// Configuration register bank with registered read and bypass
`timescale 1ns/1ps
module rps_cfg_mem #(
	parameter int DW    = 8,
	parameter int DEPTH = 32,
	parameter int AW    = 5
) (
	input  wire logic          sys_clk,
	input  wire logic          sys_rst,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic          rd_en,
	input  wire logic [AW-1:0] raddr,
	input  wire logic          bypass,
	input  wire logic [DW-1:0] bypass_data,
	output logic [DW-1:0]      rdata_q
);
	logic [DW-1:0] mem [DEPTH];

	if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_bad
		$error("rps_cfg_mem: DEPTH does not fit AW");
	end

	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Register data of the bank or of the small registers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rdata_q <= '0;
		end else if (rd_en) begin
			rdata_q <= bypass ? bypass_data : mem[raddr];
		end
	end
endmodule // rps_cfg_mem

// ==== logic/rps_sequencer.sv ====
// Power modes and start-up sequence of the reader core
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
// Functional notes
// R1: Pin high: hard power-down, oscillator off, isolated.
// R2: Power-down freezes irq, aux, serial, osc drive.
// R3: Power-down tx one follows its enable.
// R4: Power-down tx two high: enable, not inverted.
// R5: Soft sleep bit stops oscillator buffer at once.
// R6: Soft sleep indicated 512 edges after clear.
// R7: Standby bit gates digital clock, oscillator runs.
// R8: Standby leaves after four oscillator edges.
// R9: Receiver auto sleep powers receiver only when busy.
// R10: Far side holds pin high 100 us.
// R11: Reset phase 512 edges presets registers.
// R12: Init phase 128 edges copies config.
// R13: Command reads 3Fh during start-up, then 00h.
// R14: Host polls command, writes page 80h, 00h.
// R15: Counters advance only on stable oscillator edges.
module rps_sequencer (
	input  wire logic                sys_clk,
	input  wire logic                sys_rst,
	input  wire logic                power_down_reset_pin,
	input  wire logic                osc_input_pin,
	input  wire logic                osc_stable,
	input  wire rps_pkg::rps_bus_s   bus_req,
	output logic [7:0]               bus_rdata,
	output logic [4:0]               nvm_addr_q,
	input  wire logic [7:0]          nvm_data,
	input  wire rps_pkg::rps_pins_s  func_pins,
	input  wire logic                rx_busy,
	output rps_pkg::rps_pins_s       pins_q,
	output logic                     osc_drive_pin_q,
	output logic                     osc_buf_en_q,
	output logic                     clk_buf_en_q,
	output logic                     sink_en_q,
	output logic                     rx_power_en_q
);
	rps_pkg::rps_seq_e state_q;
	rps_pkg::rps_seq_e state_d;
	logic       osc_prev_q;
	logic       osc_tick;
	logic       sleep_req_q;
	logic       sleep_act_q;
	logic       stby_req_q;
	logic       stby_act_q;
	logic [7:0] txctl_q;
	logic [7:0] page_q;
	logic       iface_ok_q;
	logic       linear_q;
	logic [5:0] cmd_q;
	logic       in_pd;
	logic       in_run;
	logic       wr_run;
	logic       rd_ok;
	logic       cfg_hit;
	logic [5:0] cfg_off;
	logic       init_wr;
	logic [7:0] reg_rdata;
	logic [9:0] rst_cnt;
	logic       rst_done;
	logic [7:0] init_cnt;
	logic       init_done;
	logic [9:0] sl_cnt;
	logic       sl_done;
	logic [2:0] sb_cnt;
	logic       sb_done;

	assign in_pd   = (state_q == rps_pkg::S_PD);
	assign in_run  = (state_q == rps_pkg::S_RUN);
	assign wr_run  = bus_req.wr && in_run;
	assign rd_ok   = bus_req.rd && !in_pd;
	assign cfg_hit = (bus_req.addr >= rps_pkg::CFG_LO)
		&& (bus_req.addr <= rps_pkg::CFG_HI);
	assign cfg_off = bus_req.addr - rps_pkg::CFG_LO;

	// Edges seen only from a running, stable oscillator
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			osc_prev_q <= 1'b0;
		end else begin
			osc_prev_q <= osc_input_pin;
		end
	end
	assign osc_tick = osc_stable && osc_buf_en_q && !in_pd
		&& osc_input_pin && !osc_prev_q; // R15

	always_comb begin
		state_d = state_q;
		case (state_q)
			rps_pkg::S_PD: begin
				if (!power_down_reset_pin) state_d = rps_pkg::S_OSC;
			end
			rps_pkg::S_OSC: begin
				if (osc_stable) state_d = rps_pkg::S_RST;
			end
			rps_pkg::S_RST: begin
				if (rst_done) state_d = rps_pkg::S_INIT; // R11
			end
			rps_pkg::S_INIT: begin
				if (init_done) state_d = rps_pkg::S_RUN; // R12
			end
			rps_pkg::S_RUN: state_d = rps_pkg::S_RUN;
			default: state_d = rps_pkg::S_PD;
		endcase
		if (power_down_reset_pin) begin
			state_d = rps_pkg::S_PD; // R1
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_q <= rps_pkg::S_PD;
		end else begin
			state_q <= state_d;
		end
	end

	rps_osc_cnt #(.LIMIT(rps_pkg::RESET_CYC)) u_rst_cnt (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.clear   (state_q != rps_pkg::S_RST),
		.tick    (osc_tick), // R15
		.cnt_q   (rst_cnt),
		.done_q  (rst_done)
	);

	rps_osc_cnt #(.LIMIT(rps_pkg::INIT_CYC)) u_init_cnt (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.clear   (state_q != rps_pkg::S_INIT),
		.tick    (osc_tick),
		.cnt_q   (init_cnt),
		.done_q  (init_done)
	);

	rps_osc_cnt #(.LIMIT(rps_pkg::SLEEP_EXIT_CYC)) u_sl_cnt (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.clear   (!(sleep_act_q && !sleep_req_q)),
		.tick    (osc_tick), // R15
		.cnt_q   (sl_cnt),
		.done_q  (sl_done)
	);

	rps_osc_cnt #(.LIMIT(rps_pkg::STBY_EXIT_CYC)) u_sb_cnt (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.clear   (!(stby_act_q && !stby_req_q)),
		.tick    (osc_tick), // R15
		.cnt_q   (sb_cnt),
		.done_q  (sb_done)
	);

	// Soft sleep: request from software, indication until exit done
	always_ff @(posedge sys_clk) begin
		if (sys_rst || state_q == rps_pkg::S_RST) begin
			sleep_req_q <= 1'b0;
			sleep_act_q <= 1'b0;
		end else if (wr_run && bus_req.addr == rps_pkg::A_CTRL) begin
			sleep_req_q <= bus_req.wdata[rps_pkg::CTRL_SLEEP];
			if (bus_req.wdata[rps_pkg::CTRL_SLEEP]) begin
				sleep_act_q <= 1'b1; // R5
			end else if (sl_done) begin
				sleep_act_q <= 1'b0;
			end
		end else if (sl_done) begin
			sleep_act_q <= 1'b0; // R6
		end
	end

	// Standby: same scheme with a short exit
	always_ff @(posedge sys_clk) begin
		if (sys_rst || state_q == rps_pkg::S_RST) begin
			stby_req_q <= 1'b0;
			stby_act_q <= 1'b0;
		end else if (wr_run && bus_req.addr == rps_pkg::A_CTRL) begin
			stby_req_q <= bus_req.wdata[rps_pkg::CTRL_STBY];
			if (bus_req.wdata[rps_pkg::CTRL_STBY]) begin
				stby_act_q <= 1'b1; // R7
			end else if (sb_done) begin
				stby_act_q <= 1'b0;
			end
		end else if (sb_done) begin
			stby_act_q <= 1'b0; // R8
		end
	end

	// Transmitter and receiver control, preset in the reset phase
	always_ff @(posedge sys_clk) begin
		if (sys_rst || state_q == rps_pkg::S_RST) begin
			txctl_q <= rps_pkg::TXCTL_RST; // R11
		end else if (wr_run && bus_req.addr == rps_pkg::A_TXCTL) begin
			txctl_q <= bus_req.wdata;
		end
	end

	// Interface type handshake of the host
	always_ff @(posedge sys_clk) begin
		if (sys_rst || state_q == rps_pkg::S_RST) begin
			page_q     <= rps_pkg::PAGE_RST;
			iface_ok_q <= 1'b0;
			linear_q   <= 1'b0;
		end else if (wr_run && bus_req.addr == rps_pkg::A_PAGE) begin
			page_q <= bus_req.wdata;
			if (bus_req.wdata == rps_pkg::PAGE_IFACE) begin
				iface_ok_q <= 1'b1;
				linear_q   <= 1'b0;
			end else if (bus_req.wdata == rps_pkg::PAGE_LINEAR
				&& iface_ok_q) begin
				linear_q <= 1'b1; // R14
			end
		end
	end

	// Command value: start-up code until idle
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cmd_q <= rps_pkg::CMD_STARTUP;
		end else if (state_q == rps_pkg::S_INIT && init_done) begin
			cmd_q <= rps_pkg::CMD_IDLE; // R13
		end else if (!in_run) begin
			cmd_q <= rps_pkg::CMD_STARTUP; // R13
		end else if (wr_run && bus_req.addr == rps_pkg::A_CMD) begin
			cmd_q <= bus_req.wdata[5:0];
		end
	end

	// Configuration copy, one word per oscillator edge
	assign init_wr = (state_q == rps_pkg::S_INIT) && osc_tick
		&& (init_cnt < 8'(rps_pkg::CFG_WORDS)); // R12

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			nvm_addr_q <= '0;
		end else begin
			nvm_addr_q <= init_cnt[4:0];
		end
	end

	always_comb begin
		reg_rdata = 8'h00;
		case (bus_req.addr)
			rps_pkg::A_PAGE: reg_rdata = page_q;
			rps_pkg::A_CMD: reg_rdata = {2'b00, cmd_q};
			rps_pkg::A_TXCTL: reg_rdata = txctl_q;
			rps_pkg::A_CTRL: begin
				reg_rdata[rps_pkg::CTRL_SLEEP] = sleep_act_q; // R6
				reg_rdata[rps_pkg::CTRL_STBY]  = stby_act_q; // R8
			end
			rps_pkg::A_STATUS: begin
				reg_rdata[rps_pkg::ST_SLEEP]  = sleep_act_q;
				reg_rdata[rps_pkg::ST_STBY]   = stby_act_q;
				reg_rdata[rps_pkg::ST_IFACE]  = iface_ok_q;
				reg_rdata[rps_pkg::ST_LINEAR] = linear_q;
				reg_rdata[rps_pkg::ST_RUN]    = in_run;
			end
			default: reg_rdata = 8'h00;
		endcase
	end

	rps_cfg_mem #(
		.DW    (rps_pkg::DATA_W),
		.DEPTH (rps_pkg::CFG_WORDS),
		.AW    (rps_pkg::CFG_W)
	) u_cfg_mem (
		.sys_clk     (sys_clk),
		.sys_rst     (sys_rst),
		.we          (init_wr || (wr_run && cfg_hit)),
		.waddr       (init_wr ? nvm_addr_q : cfg_off[4:0]),
		.wdata       (init_wr ? nvm_data : bus_req.wdata),
		.rd_en       (rd_ok),
		.raddr       (cfg_off[4:0]),
		.bypass      (!cfg_hit),
		.bypass_data (reg_rdata),
		.rdata_q     (bus_rdata)
	);

	// Pin outputs: forced in power-down, held while asleep
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pins_q <= '0;
		end else if (in_pd) begin
			pins_q.irq        <= 1'b0;
			pins_q.irq_oe     <= 1'b0; // R2
			pins_q.aux        <= 1'b0;
			pins_q.aux_oe     <= 1'b0; // R2
			pins_q.aux_serial <= 1'b0; // R2
			pins_q.tx1 <= txctl_q[rps_pkg::TX1_EN]; // R3
			pins_q.tx2 <= txctl_q[rps_pkg::TX2_EN]
				&& !txctl_q[rps_pkg::TX2_INV]; // R4
		end else if (!sleep_act_q && !stby_act_q) begin
			pins_q <= func_pins; // R5 R7
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			osc_drive_pin_q <= 1'b1;
		end else if (in_pd) begin
			osc_drive_pin_q <= 1'b1; // R2
		end else if (osc_buf_en_q) begin
			osc_drive_pin_q <= !osc_input_pin;
		end
	end

	// Analog enables
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			osc_buf_en_q  <= 1'b0;
			clk_buf_en_q  <= 1'b0;
			sink_en_q     <= 1'b0;
			rx_power_en_q <= 1'b0;
		end else begin
			osc_buf_en_q <= !in_pd && !power_down_reset_pin
				&& !sleep_req_q; // R1 R5
			clk_buf_en_q <= !in_pd && !sleep_act_q && !stby_act_q; // R7
			sink_en_q    <= !in_pd && !sleep_act_q && !stby_act_q; // R1
			rx_power_en_q <= !in_pd && !sleep_act_q
				&& (!txctl_q[rps_pkg::RX_AUTO] || rx_busy); // R9
		end
	end

	a_pd_entry: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
		power_down_reset_pin |=> in_pd ##1 (!osc_buf_en_q && !sink_en_q))
		else $error("power-down not entered");
	a_pd_freeze: assert property (@(posedge sys_clk) disable iff (sys_rst) // R2
		in_pd |=> !pins_q.irq_oe && !pins_q.aux_oe && !pins_q.aux_serial
			&& osc_drive_pin_q)
		else $error("pins not frozen in power-down");
	a_pd_tx_one: assert property (@(posedge sys_clk) disable iff (sys_rst) // R3
		in_pd |=> pins_q.tx1 == $past(txctl_q[rps_pkg::TX1_EN]))
		else $error("tx one wrong in power-down");
	a_pd_tx_two: assert property (@(posedge sys_clk) disable iff (sys_rst) // R4
		in_pd |=> pins_q.tx2 == $past(txctl_q[rps_pkg::TX2_EN]
			&& !txctl_q[rps_pkg::TX2_INV]))
		else $error("tx two wrong in power-down");
	a_sleep_enter: assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
		wr_run && bus_req.addr == rps_pkg::A_CTRL
			&& bus_req.wdata[rps_pkg::CTRL_SLEEP] && !power_down_reset_pin
		|=> sleep_act_q ##1 !osc_buf_en_q)
		else $error("soft sleep not entered");
	a_sleep_exit: assert property (@(posedge sys_clk) disable iff (sys_rst) // R6
		$fell(sleep_act_q) && in_run |-> $past(sl_cnt) == rps_pkg::SLEEP_EXIT_CYC)
		else $error("soft sleep left early");
	a_stby_clk: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
		stby_act_q && !power_down_reset_pin |=> !clk_buf_en_q && osc_buf_en_q
			== $past(!in_pd && !sleep_req_q))
		else $error("standby clock gating wrong");
	a_stby_exit: assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
		$fell(stby_act_q) && in_run |-> $past(sb_cnt) == rps_pkg::STBY_EXIT_CYC)
		else $error("standby left early");
	a_rx_power: assert property (@(posedge sys_clk) disable iff (sys_rst) // R9
		in_run && !sleep_act_q && !txctl_q[rps_pkg::RX_AUTO] |=> rx_power_en_q)
		else $error("receiver powered down without auto mode");
	a_reset_len: assert property (@(posedge sys_clk) disable iff (sys_rst) // R11
		$rose(state_q == rps_pkg::S_INIT) |-> $past(rst_cnt) == rps_pkg::RESET_CYC)
		else $error("reset phase length wrong");
	a_init_len: assert property (@(posedge sys_clk) disable iff (sys_rst) // R12
		$rose(in_run) |-> $past(init_cnt) == rps_pkg::INIT_CYC
			&& cmd_q == rps_pkg::CMD_IDLE)
		else $error("init phase length or idle code wrong");
	a_cmd_start: assert property (@(posedge sys_clk) disable iff (sys_rst) // R13
		state_q == rps_pkg::S_RST || state_q == rps_pkg::S_INIT
		|-> cmd_q == rps_pkg::CMD_STARTUP)
		else $error("start-up command value wrong");
	a_osc_gate: assert property (@(posedge sys_clk) disable iff (sys_rst) // R15
		!osc_stable |=> $stable(rst_cnt) || rst_cnt == '0)
		else $error("counter advanced without oscillator");
endmodule // rps_sequencer

// ==== tb/rps_host_model.sv ====
// Host microprocessor model driving the register port
`timescale 1ns/1ps
module rps_host_model (
	input  wire logic         sys_clk,
	input  wire logic [7:0]   bus_rdata,
	output rps_pkg::rps_bus_s bus_req
);
	initial bus_req = '0;

	task automatic bus_write(input logic [5:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask

	// Data taken at the edge closing the cycle after the strobe
	task automatic bus_read(input logic [5:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		@(posedge sys_clk);
		d = bus_rdata;
	endtask

	// Interface type handshake; ok stays low if idle never shows
	task automatic start_iface(output logic ok);
		logic [7:0] v;
		int         n;
		ok = 1'b0;
		n = 0;
		v = 8'hFF;
		while (v[5:0] !== rps_pkg::CMD_IDLE && n < 2000) begin
			bus_read(rps_pkg::A_CMD, v);
			n++;
		end
		if (v[5:0] === rps_pkg::CMD_IDLE) begin
			bus_write(rps_pkg::A_PAGE, rps_pkg::PAGE_IFACE);
			bus_read(rps_pkg::A_CMD, v);
			ok = (v[5:0] === rps_pkg::CMD_IDLE);
			bus_write(rps_pkg::A_PAGE, rps_pkg::PAGE_LINEAR);
		end
	endtask
endmodule // rps_host_model

// ==== tb/rps_sequencer_tb_top.sv ====
// Self-checking bench of the power and start-up sequencer
`timescale 1ns/1ps
module rps_sequencer_tb_top;
	logic               sys_clk, sys_rst, power_down_reset_pin, rx_busy;
	logic               osc_input_pin, osc_stable, osc_run, ok;
	logic [1:0]         div_q;
	logic [7:0]         bus_rdata, nvm_data, rd_v;
	logic [4:0]         nvm_addr_q;
	rps_pkg::rps_bus_s  bus_req;
	rps_pkg::rps_pins_s func_pins, pins_q;
	logic               osc_drive_pin_q, osc_buf_en_q, clk_buf_en_q;
	logic               sink_en_q, rx_power_en_q;
	int                 failures, num_checks, cycles;
	logic [7:0]         tx_set [4] = '{8'h01, 8'h02, 8'h0A, 8'h0B};

	rps_sequencer i_dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst),
		.power_down_reset_pin(power_down_reset_pin),
		.osc_input_pin(osc_input_pin), .osc_stable(osc_stable),
		.bus_req(bus_req), .bus_rdata(bus_rdata),
		.nvm_addr_q(nvm_addr_q), .nvm_data(nvm_data),
		.func_pins(func_pins), .rx_busy(rx_busy), .pins_q(pins_q),
		.osc_drive_pin_q(osc_drive_pin_q), .osc_buf_en_q(osc_buf_en_q),
		.clk_buf_en_q(clk_buf_en_q), .sink_en_q(sink_en_q),
		.rx_power_en_q(rx_power_en_q)
	);

	rps_host_model i_host (
		.sys_clk(sys_clk), .bus_rdata(bus_rdata), .bus_req(bus_req)
	);

	// Config store: byte depends on its index
	assign nvm_data = 8'hA0 ^ {3'h0, nvm_addr_q};

	always #10 sys_clk = ~sys_clk;

	// Oscillator at a quarter of the clock, still while stopped
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (osc_run) begin
			div_q <= div_q + 2'h1;
			osc_input_pin <= div_q[1];
		end
	end

	always @(posedge sys_clk) begin
		if (cycles >= 90000) begin
			failures++;
			conclude();
		end
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic read_check(input logic [5:0] a, input logic [7:0] exp);
		i_host.bus_read(a, rd_v);
		check_val(rd_v, exp);
	endtask

	// Frozen pins and stopped analog parts in hard power-down
	task automatic pd_check(input logic [7:0] tx);
		check_val({3'h0, pins_q.irq_oe, pins_q.aux_oe, pins_q.aux_serial,
			pins_q.tx1, pins_q.tx2}, {6'h00, tx[0], tx[1] & ~tx[3]});
		check_val({5'h00, osc_drive_pin_q, osc_buf_en_q, sink_en_q}, 8'h04);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		sys_rst = 1'b1;
		power_down_reset_pin = 1'b1;
		osc_input_pin = 1'b0;
		osc_stable = 1'b0;
		osc_run = 1'b0;
		rx_busy = 1'b0;
		div_q = 2'h0;
		func_pins = '1;
		failures = 0;
		num_checks = 0;
		cycles = 0;
		wait_cyc(5);
		sys_rst <= 1'b0;
		wait_cyc(rps_pkg::PD_MIN_CYC);
		pd_check(8'h00);
		power_down_reset_pin <= 1'b0;
		osc_run <= 1'b1;
		wait_cyc(3000);
		read_check(rps_pkg::A_CMD, 8'h3F);
		osc_stable <= 1'b1;
		wait_cyc(2400);
		read_check(rps_pkg::A_CMD, {2'b00, rps_pkg::CMD_STARTUP});
		i_host.start_iface(ok);
		check_val({7'h00, ok}, 8'h01);
		read_check(rps_pkg::A_STATUS, 8'h1C);
		for (int k = 0; k < rps_pkg::CFG_WORDS; k++)
			read_check(rps_pkg::CFG_LO + 6'(k), 8'hA0 ^ 8'(k));
		read_check(6'h3F, 8'h00);
		// Soft sleep holds pins and stops the oscillator buffer
		i_host.bus_write(rps_pkg::A_CTRL, 8'h10);
		wait_cyc(2);
		func_pins <= '0;
		wait_cyc(3);
		check_val({1'b0, pins_q}, 8'h7F);
		check_val({7'h00, osc_buf_en_q}, 8'h00);
		i_host.bus_write(rps_pkg::A_CTRL, 8'h00);
		read_check(rps_pkg::A_CTRL, 8'h10);
		// Exit count must stand still while the oscillator is unstable
		osc_stable <= 1'b0;
		wait_cyc(2400);
		read_check(rps_pkg::A_CTRL, 8'h10);
		osc_stable <= 1'b1;
		wait_cyc(1900);
		read_check(rps_pkg::A_CTRL, 8'h10);
		wait_cyc(300);
		read_check(rps_pkg::A_CTRL, 8'h00);
		func_pins <= '1;
		// Standby gates the digital clock but keeps the oscillator buffer on
		i_host.bus_write(rps_pkg::A_CTRL, 8'h20);
		wait_cyc(2);
		check_val({6'h00, clk_buf_en_q, osc_buf_en_q}, 8'h01);
		// Oscillator drive keeps following its input in standby
		repeat (2) begin
			rd_v = {7'h00, ~osc_input_pin};
			wait_cyc(1);
			check_val({7'h00, osc_drive_pin_q}, rd_v);
			wait_cyc(1);
		end
		i_host.bus_write(rps_pkg::A_CTRL, 8'h00);
		read_check(rps_pkg::A_CTRL, 8'h20);
		wait_cyc(40);
		read_check(rps_pkg::A_CTRL, 8'h00);
		check_val({6'h00, clk_buf_en_q, osc_buf_en_q}, 8'h03);
		// Receiver power with and without auto sleep
		i_host.bus_write(rps_pkg::A_TXCTL, 8'h10);
		wait_cyc(3);
		check_val({7'h00, rx_power_en_q}, 8'h00);
		rx_busy <= 1'b1;
		wait_cyc(3);
		check_val({7'h00, rx_power_en_q}, 8'h01);
		rx_busy <= 1'b0;
		i_host.bus_write(rps_pkg::A_TXCTL, 8'h00);
		wait_cyc(3);
		check_val({7'h00, rx_power_en_q}, 8'h01);
		// Hard power-down with four transmitter settings
		foreach (tx_set[i]) begin
			i_host.bus_write(rps_pkg::A_TXCTL, tx_set[i]);
			wait_cyc(3);
			power_down_reset_pin <= 1'b1;
			osc_run <= 1'b0;
			osc_stable <= 1'b0;
			wait_cyc(rps_pkg::PD_MIN_CYC);
			pd_check(tx_set[i]);
			power_down_reset_pin <= 1'b0;
			osc_run <= 1'b1;
			osc_stable <= 1'b1;
			i_host.start_iface(ok);
			check_val({7'h00, ok}, 8'h01);
			read_check(rps_pkg::A_TXCTL, rps_pkg::TXCTL_RST);
		end
		conclude();
	end
endmodule // rps_sequencer_tb_top
